// ==== design/bcwf_pkg.sv ====
// constants, layouts and states of the capture word formatter
// assumes one word clock; every user of it names bcwf_pkg:: explicitly
package bcwf_pkg;
  localparam int WORD_W = 24;
  localparam int INFO_W = 16;
  typedef struct packed {
    logic       msb;
    logic [2:0] label;
    logic [3:0] content;
    logic [15:0] info;
  } bcwf_word_t;
  typedef struct packed {
    logic [3:0]  label;
    logic [3:0]  content;
    logic [15:0] info;
  } bcwf_cap_t;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLEN = 8'h04;
  localparam logic [7:0] OFS_LBL  = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_OVFC = 8'h10;
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_PAR  = 1;
  localparam int CTRL_CRC  = 2;
  localparam int CTRL_TIME = 3;
  localparam int CTRL_RSP  = 4;
  localparam logic [4:0]  CTRL_RST = 5'h00;
  localparam logic [9:0]  FLEN_RST = 10'h080;
  localparam logic [9:0]  FLEN_MIN = 10'h080;
  localparam logic [9:0]  FLEN_MAX = 10'h200;
  localparam logic [19:0] LBL_RST  = 20'h07010;
  localparam logic [3:0]  CL_OVF   = 4'h0;
  localparam logic [3:0]  CL_THI   = 4'h4;
  localparam logic [3:0]  CL_TLO   = 4'h5;
  localparam logic [3:0]  CL_TUS   = 4'h6;
  localparam logic [3:0]  CL_TRSP  = 4'h3;
  localparam logic [15:0] FILL_INFO = 16'haaaa;
  localparam logic [23:0] SYNC_WORD = 24'hfaf320;
  localparam logic [15:0] CRC_POLY  = 16'h8005;
  localparam logic [15:0] CRC_INIT  = 16'h0000;
  localparam logic [4:0]  SER_BITS  = 5'h18;
  typedef enum logic [2:0] {
    ST_SYNC, ST_THI, ST_TLO, ST_TUS, ST_TRSP, ST_DATA, ST_CRCW
  } bcwf_state_t;
  typedef enum logic [2:0] {
    K_SYNC, K_TIME, K_DATA, K_FILL, K_OVF, K_CRC
  } bcwf_kind_t;
endpackage

// ==== design/bcwf_crc16.sv ====
// frame check accumulator, one 24-bit word per enable, msb first
// assumes the caller never feeds the check word itself
module bcwf_crc16 (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        en,
  input  wire logic        clear,
  input  wire logic [23:0] word,
  output logic      [15:0] crc_r
);
  function automatic logic [15:0] bcwf_upd(input logic [15:0] c, input logic [23:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 23; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ bcwf_pkg::CRC_POLY; // RL12
      end
    end
    return r;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_r <= bcwf_pkg::CRC_INIT;
    end else if (en) begin
      crc_r <= bcwf_upd(clear ? bcwf_pkg::CRC_INIT : crc_r, word);
    end
  end
endmodule

// ==== design/bcwf_ser.sv ====
// word serializer, msb first, one bit per divider tick
// assumes load only while ready is high
module bcwf_ser #(
  parameter int DIV = 4
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        load,
  input  wire logic [23:0] word,
  output logic             ready,
  output logic             pcm_bit_r,
  output logic             pcm_stb_r
);
  logic [7:0]  div_r;
  logic [23:0] shift_r;
  logic [4:0]  cnt_r;
  logic        tick;

  assign tick  = (div_r == 8'(DIV - 1));
  // accept the next word on the last tick so bits stay back to back
  assign ready = (cnt_r == 5'h00) || (cnt_r == 5'h01 && tick);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 8'h00;
    end else begin
      div_r <= tick ? 8'h00 : div_r + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r <= 24'h000000;
      cnt_r   <= 5'h00;
    end else if (load) begin
      shift_r <= word;
      cnt_r   <= bcwf_pkg::SER_BITS;
    end else if (tick && cnt_r != 5'h00) begin
      shift_r <= {shift_r[22:0], 1'b0}; // RL17
      cnt_r   <= cnt_r - 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcm_bit_r <= 1'b0;
      pcm_stb_r <= 1'b0;
    end else begin
      pcm_stb_r <= tick && cnt_r != 5'h00;
      if (tick && cnt_r != 5'h00) begin
        pcm_bit_r <= shift_r[23]; // RL17
      end
    end
  end

  a_ser_msb: assert property (@(posedge hclk) disable iff (!hresetn) // RL17
    pcm_stb_r |-> pcm_bit_r == $past(shift_r[23]))
    else $error("serializer bit not from shift msb");
  a_ser_shift: assert property (@(posedge hclk) disable iff (!hresetn) // RL17
    tick && cnt_r != 5'h00 && !load |=> shift_r[23] == $past(shift_r[22]))
    else $error("serializer does not shift towards msb");
endmodule

// ==== design/bcwf_top.sv ====
// capture word formatter: builds 24-bit formatted words into PCM frames
// assumes capture, overflow and time inputs come from logic on hclk
//
// Notes on behaviour
// (RL1) every output word is 24 bits
// (RL2) parity option: msb makes word odd parity
// (RL3) label 3 bits with parity, 4 without
// (RL4) one label per bus or channel group
// (RL5) every word gets a 4-bit content label
// (RL6) information bits copied in original order
// (RL7) idle slots carry fill pattern aaaa
// (RL8) overflow marker first, content 0000, source label
// (RL9) marker low 16 bits carry diagnostics
// (RL10) crc word is last word of frame
// (RL11) crc word: labels above, check below
// (RL12) check polynomial x16+x15+x2+1
// (RL13) check word excluded from its own check
// (RL14) crc content label should avoid 1xxx codes
// (RL15) high, low, microsecond time words, bit order
// (RL16) optional response time word after microseconds
// (RL17) serial output msb first
// (RL18) fixed frame length 128 to 512 words
// (RL19) label bits 2-4, content bits 5-8
// (RL20) configuration frozen while recording
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
module bcwf_top #(
  parameter int BIT_DIV = 4
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                cap_valid,
  output logic                     cap_ready,
  input  wire bcwf_pkg::bcwf_cap_t cap_word,
  input  wire logic                ovf_evt,
  input  wire logic [3:0]          ovf_label,
  input  wire logic [15:0]         time_hi,
  input  wire logic [15:0]         time_lo,
  input  wire logic [15:0]         time_us,
  input  wire logic [15:0]         time_rsp,
  output logic                     pcm_bit,
  output logic                     pcm_stb,
  output logic [23:0]              fmt_word,
  output logic                     fmt_valid,
  output logic                     frame_start
);
  logic [4:0]            ctrl_r;
  logic [9:0]            flen_r;
  logic [19:0]           lbl_r;
  logic [15:0]           fcnt_r;
  logic [15:0]           ovfc_r;
  logic                  ovf_pend_r;
  logic [3:0]            ovf_lbl_r;
  logic [9:0]            idx_r;
  bcwf_pkg::bcwf_state_t state_r;
  bcwf_pkg::bcwf_state_t state_nxt;
  bcwf_pkg::bcwf_kind_t  kind_r;
  bcwf_pkg::bcwf_kind_t  kind_nxt;
  logic                  ap_act_r;
  logic                  ap_we_r;
  logic [7:0]            ap_addr_r;
  logic [31:0]           rdata_r;
  logic                  ser_ready;
  logic                  go;
  logic                  busy;
  logic                  par_en;
  logic                  crc_en;
  logic                  time_en;
  logic                  rsp_en;
  logic                  last_slot;
  logic [15:0]           crc;
  logic [3:0]            w_label;
  logic [3:0]            w_content;
  logic [15:0]           w_info;
  logic [22:0]           w_low;
  logic [23:0]           word;
  logic [9:0]            wd_len;

  assign par_en  = ctrl_r[bcwf_pkg::CTRL_PAR];
  assign crc_en  = ctrl_r[bcwf_pkg::CTRL_CRC];
  assign time_en = ctrl_r[bcwf_pkg::CTRL_TIME];
  assign rsp_en  = ctrl_r[bcwf_pkg::CTRL_RSP];
  // a frame in flight always completes after run is cleared
  assign busy    = ctrl_r[bcwf_pkg::CTRL_RUN] || state_r != bcwf_pkg::ST_SYNC;
  assign go      = ser_ready && busy;
  assign last_slot = (idx_r == flen_r - 10'h001);

  // bus slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;
  assign wd_len    = hwdata[9:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_act_r  <= 1'b0;
      ap_we_r   <= 1'b0;
      ap_addr_r <= 8'h00;
    end else if (hready) begin
      ap_act_r  <= hsel && htrans[1];
      ap_we_r   <= hwrite;
      ap_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        bcwf_pkg::OFS_CTRL: rdata_r <= {27'h0000000, ctrl_r};
        bcwf_pkg::OFS_FLEN: rdata_r <= {22'h000000, flen_r};
        bcwf_pkg::OFS_LBL:  rdata_r <= {12'h000, lbl_r};
        bcwf_pkg::OFS_STAT: rdata_r <= {14'h0000, busy, ovf_pend_r, fcnt_r};
        bcwf_pkg::OFS_OVFC: rdata_r <= {16'h0000, ovfc_r};
        default:            rdata_r <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= bcwf_pkg::CTRL_RST;
      flen_r <= bcwf_pkg::FLEN_RST;
      lbl_r  <= bcwf_pkg::LBL_RST;
    end else if (ap_act_r && ap_we_r) begin
      if (ap_addr_r == bcwf_pkg::OFS_CTRL) begin
        ctrl_r[bcwf_pkg::CTRL_RUN] <= hwdata[bcwf_pkg::CTRL_RUN];
        if (!busy) begin
          ctrl_r[4:1] <= hwdata[4:1]; // RL20
        end
      end
      if (ap_addr_r == bcwf_pkg::OFS_FLEN && !busy) begin
        if (hwdata[31:10] != 22'h000000 || wd_len > bcwf_pkg::FLEN_MAX) begin
          flen_r <= bcwf_pkg::FLEN_MAX; // RL18
        end else if (wd_len < bcwf_pkg::FLEN_MIN) begin
          flen_r <= bcwf_pkg::FLEN_MIN; // RL18
        end else begin
          flen_r <= wd_len;
        end
      end
      if (ap_addr_r == bcwf_pkg::OFS_LBL && !busy) begin
        lbl_r <= hwdata[19:0]; // RL20
      end
    end
  end

  // overflow marker pending: a new event in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_pend_r <= 1'b0;
      ovf_lbl_r  <= 4'h0;
      ovfc_r     <= 16'h0000;
    end else begin
      if (ovf_evt) begin
        ovf_pend_r <= 1'b1; // RL8
        ovf_lbl_r  <= ovf_label;
        ovfc_r     <= ovfc_r + 16'h0001;
      end else if (go && kind_nxt == bcwf_pkg::K_OVF) begin
        ovf_pend_r <= 1'b0;
      end
    end
  end

  assign cap_ready = go && state_r == bcwf_pkg::ST_DATA && !ovf_pend_r; // RL8

  always_comb begin
    kind_nxt  = bcwf_pkg::K_FILL;
    w_label   = lbl_r[3:0];
    w_content = lbl_r[7:4];
    w_info    = bcwf_pkg::FILL_INFO; // RL7
    case (state_r)
      bcwf_pkg::ST_SYNC: begin
        kind_nxt = bcwf_pkg::K_SYNC;
      end
      bcwf_pkg::ST_THI, bcwf_pkg::ST_TLO, bcwf_pkg::ST_TUS, bcwf_pkg::ST_TRSP: begin
        kind_nxt = bcwf_pkg::K_TIME;
        w_label  = lbl_r[19:16];
        case (state_r)
          bcwf_pkg::ST_THI: begin
            w_content = bcwf_pkg::CL_THI; // RL15
            w_info    = time_hi;
          end
          bcwf_pkg::ST_TLO: begin
            w_content = bcwf_pkg::CL_TLO; // RL15
            w_info    = time_lo;
          end
          bcwf_pkg::ST_TUS: begin
            w_content = bcwf_pkg::CL_TUS; // RL15
            w_info    = time_us;
          end
          default: begin
            w_content = bcwf_pkg::CL_TRSP; // RL16
            w_info    = time_rsp;
          end
        endcase
      end
      bcwf_pkg::ST_CRCW: begin
        kind_nxt  = bcwf_pkg::K_CRC;
        w_label   = lbl_r[11:8]; // RL11
        w_content = lbl_r[15:12]; // RL14
        w_info    = crc; // RL11
      end
      bcwf_pkg::ST_DATA: begin
        if (ovf_pend_r) begin
          kind_nxt  = bcwf_pkg::K_OVF;
          w_label   = ovf_lbl_r; // RL8
          w_content = bcwf_pkg::CL_OVF; // RL8
          w_info    = ovfc_r; // RL9
        end else if (cap_valid) begin
          kind_nxt  = bcwf_pkg::K_DATA;
          w_label   = cap_word.label; // RL4
          w_content = cap_word.content; // RL5
          w_info    = cap_word.info; // RL6
        end
      end
      default: begin
        kind_nxt = bcwf_pkg::K_FILL;
      end
    endcase
  end

  // bit 1 is the msb: parity, or the top label bit when parity is off
  assign w_low = {w_label[2:0], w_content, w_info}; // RL19
  always_comb begin
    if (kind_nxt == bcwf_pkg::K_SYNC) begin
      word = bcwf_pkg::SYNC_WORD;
    end else if (par_en) begin
      word = {~^w_low, w_low}; // RL2
    end else begin
      word = {w_label[3], w_low}; // RL3
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bcwf_pkg::ST_SYNC: state_nxt = time_en ? bcwf_pkg::ST_THI : bcwf_pkg::ST_DATA;
      bcwf_pkg::ST_THI:  state_nxt = bcwf_pkg::ST_TLO;
      bcwf_pkg::ST_TLO:  state_nxt = bcwf_pkg::ST_TUS;
      bcwf_pkg::ST_TUS:  state_nxt = rsp_en ? bcwf_pkg::ST_TRSP : bcwf_pkg::ST_DATA; // RL16
      bcwf_pkg::ST_TRSP: state_nxt = bcwf_pkg::ST_DATA;
      bcwf_pkg::ST_CRCW: state_nxt = bcwf_pkg::ST_SYNC;
      default:           state_nxt = bcwf_pkg::ST_DATA;
    endcase
    if (state_r != bcwf_pkg::ST_CRCW) begin
      if (last_slot) begin
        state_nxt = bcwf_pkg::ST_SYNC; // RL18
      end else if (crc_en && idx_r == flen_r - 10'h002) begin
        state_nxt = bcwf_pkg::ST_CRCW; // RL10
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= bcwf_pkg::ST_SYNC;
      idx_r   <= 10'h000;
      fcnt_r  <= 16'h0000;
    end else if (go) begin
      state_r <= state_nxt;
      idx_r   <= last_slot ? 10'h000 : idx_r + 10'h001; // RL18
      if (state_r == bcwf_pkg::ST_SYNC) begin
        fcnt_r <= fcnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fmt_word    <= 24'h000000;
      fmt_valid   <= 1'b0;
      frame_start <= 1'b0;
      kind_r      <= bcwf_pkg::K_SYNC;
    end else begin
      fmt_valid   <= go;
      frame_start <= go && state_r == bcwf_pkg::ST_SYNC;
      if (go) begin
        fmt_word <= word; // RL1
        kind_r   <= kind_nxt;
      end
    end
  end

  bcwf_crc16 u_crc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (go && state_r != bcwf_pkg::ST_CRCW), // RL13
    .clear   (state_r == bcwf_pkg::ST_SYNC),
    .word    (word),
    .crc_r   (crc)
  );

  bcwf_ser #(
    .DIV (BIT_DIV)
  ) u_ser (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .load      (go),
    .word      (word),
    .ready     (ser_ready),
    .pcm_bit_r (pcm_bit),
    .pcm_stb_r (pcm_stb)
  );

  a_odd_parity: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
    fmt_valid && par_en && kind_r != bcwf_pkg::K_SYNC |-> ^fmt_word)
    else $error("formatted word lacks odd parity");
  a_fill_pattern: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
    fmt_valid && kind_r == bcwf_pkg::K_FILL |-> fmt_word[15:0] == bcwf_pkg::FILL_INFO)
    else $error("fill word pattern wrong");
  a_ovf_marker: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
    fmt_valid && kind_r == bcwf_pkg::K_OVF |-> fmt_word[19:16] == bcwf_pkg::CL_OVF
      && fmt_word[22:20] == $past(ovf_lbl_r[2:0]))
    else $error("overflow marker labels wrong");
  a_ovf_before_data: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
    ovf_evt |=> !cap_ready throughout (ovf_pend_r [*1]))
    else $error("data taken before overflow marker");
  a_data_copy: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
    cap_valid && cap_ready |=> fmt_word[15:0] == $past(cap_word.info)
      && fmt_word[19:16] == $past(cap_word.content))
    else $error("captured bits not copied in order");
  a_crc_last: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
    go && state_r == bcwf_pkg::ST_CRCW |-> last_slot && crc_en)
    else $error("crc word not in last slot");
  a_crc_value: assert property (@(posedge hclk) disable iff (!hresetn) // RL13
    fmt_valid && kind_r == bcwf_pkg::K_CRC |-> fmt_word[15:0] == crc)
    else $error("crc word does not hold frame check");
  a_sync_first: assert property (@(posedge hclk) disable iff (!hresetn) // RL18
    frame_start |-> fmt_word == bcwf_pkg::SYNC_WORD && kind_r == bcwf_pkg::K_SYNC)
    else $error("frame does not open with sync");
  a_frame_len: assert property (@(posedge hclk) disable iff (!hresetn) // RL18
    frame_start |-> ##1 (!frame_start)[*8])
    else $error("frame shorter than minimum");
  a_cfg_frozen: assert property (@(posedge hclk) disable iff (!hresetn) // RL20
    busy && $past(busy) |-> $stable(ctrl_r[4:1]) && $stable(flen_r))
    else $error("configuration changed while recording");
  c_ovf_marker: cover property (@(posedge hclk) disable iff (!hresetn)
    fmt_valid && kind_r == bcwf_pkg::K_OVF);
  c_crc_word: cover property (@(posedge hclk) disable iff (!hresetn)
    fmt_valid && kind_r == bcwf_pkg::K_CRC);
  c_time_word: cover property (@(posedge hclk) disable iff (!hresetn)
    fmt_valid && kind_r == bcwf_pkg::K_TIME);
  c_data_fill: cover property (@(posedge hclk) disable iff (!hresetn)
    fmt_valid && kind_r == bcwf_pkg::K_DATA ##1 fmt_valid && kind_r == bcwf_pkg::K_FILL);
endmodule

// ==== tb/bcwf_pcm_rx.sv ====
// partner model: pcm receiver rebuilding 24-bit words from the serial line
// assumes pcm_bit is settled whenever pcm_stb pulses, and words run back to back
module bcwf_pcm_rx (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        pcm_bit,
  input  wire logic        pcm_stb,
  output logic      [23:0] rx_word,
  output logic             rx_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] sh_r;
  logic [4:0]  cnt_r;
  // shift in msb first; the 24th strobe closes a word, so any slip shows at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_r <= 24'h000000;
      cnt_r <= 5'h00;
      rx_word <= 24'h000000;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (pcm_stb) begin
        sh_r <= {sh_r[22:0], pcm_bit};
        if (cnt_r == 5'h17) begin
          cnt_r <= 5'h00;
          rx_word <= {sh_r[22:0], pcm_bit};
          rx_valid <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 5'h01;
        end
      end
    end
  end
endmodule

// ==== tb/testbench.sv ====
// testbench: registers over ahb-lite, capture feed, frame and serial checks
// assumes the design's own assertions run alongside; one hclk domain
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 2;
  logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]         haddr, hwdata, hrdata, rd;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic                cap_valid, cap_ready, ovf_evt;
  bcwf_pkg::bcwf_cap_t cap_word;
  logic [3:0]          ovf_label;
  logic [15:0]         time_hi, time_lo, time_us, time_rsp, crc;
  logic                pcm_bit, pcm_stb, fmt_valid, frame_start, rx_valid;
  logic [23:0]         fmt_word, rx_word, m_exp, mask;
  logic                par_on, crc_on, tim_on, rsp_on;
  logic [9:0]          flen;
  logic [19:0]         lbl;
  logic [24:0]         e;
  logic [24:0]         exp_q[$];
  logic [23:0]         sent_q[$];
  int                  num_errors, comparisons, pos, nt, cycles;

  bcwf_top #(.BIT_DIV(DIV)) bcwf_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cap_valid(cap_valid),
    .cap_ready(cap_ready), .cap_word(cap_word), .ovf_evt(ovf_evt),
    .ovf_label(ovf_label), .time_hi(time_hi), .time_lo(time_lo), .time_us(time_us),
    .time_rsp(time_rsp), .pcm_bit(pcm_bit), .pcm_stb(pcm_stb), .fmt_word(fmt_word),
    .fmt_valid(fmt_valid), .frame_start(frame_start)
  );
  bcwf_pcm_rx bcwf_pcm_rx_i (
    .hclk(hclk), .hresetn(hresetn), .pcm_bit(pcm_bit), .pcm_stb(pcm_stb),
    .rx_word(rx_word), .rx_valid(rx_valid)
  );

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic complete_run();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] ex, input string m);
    comparisons++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, m, got, ex);
    end
  endtask

  // msb-first crc, one whole word at a time
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      if (c[15] ^ w[i])
        c = (c << 1) ^ 16'h8005;
      else
        c = c << 1;
    end
    return c;
  endfunction

  function automatic logic [23:0] mk(logic [3:0] l, logic [3:0] c, logic [15:0] d);
    logic [23:0] w;
    w = {l, c, d};
    if (par_on)
      w[23] = ~^w[22:0];
    return w;
  endfunction

  // one single transfer; hready is the slave's own hreadyout
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input string m);
    ahb(1'b0, a, 32'h00000000, rd);
    check(rd, ex, m);
    check({31'h00000000, hresp}, 32'h00000000, "okay response");
  endtask

  task automatic cap(input logic [23:0] w);
    @(posedge hclk);
    cap_valid <= 1'b1;
    cap_word <= w;
    @(posedge hclk);
    while (cap_ready !== 1'b1) @(posedge hclk);
    exp_q.push_back({1'b0, w});
    cap_valid <= 1'b0;
  endtask

  // raise the overflow just after a word went out, clear of the next slot
  task automatic ovf(input logic [3:0] l);
    @(posedge hclk);
    while (fmt_valid !== 1'b1) @(posedge hclk);
    ovf_evt <= 1'b1;
    ovf_label <= l;
    exp_q.push_back({1'b1, l, 20'h00000});
    @(posedge hclk);
    ovf_evt <= 1'b0;
  endtask

  task automatic stop_wait(input logic [31:0] c);
    ahb(1'b1, bcwf_pkg::OFS_CTRL, c, rd);
    rd = 32'h00020000;
    while (rd[17]) ahb(1'b0, bcwf_pkg::OFS_STAT, 32'h00000000, rd);
    check(pos, flen, "last frame length");
    check(exp_q.size(), 0, "captures left over");
    pos = 0;
  endtask

  // stream monitor: classifies each word by its slot in the frame
  always @(posedge hclk) begin
    if (fmt_valid === 1'b1) begin
      sent_q.push_back(fmt_word);
      if (frame_start === 1'b1) begin
        if (pos != 0) check(pos, flen, "frame length");
        check(fmt_word, bcwf_pkg::SYNC_WORD, "sync word");
        crc = crc_step(bcwf_pkg::CRC_INIT, fmt_word);
        pos = 1;
      end else begin
        nt = tim_on ? (rsp_on ? 4 : 3) : 0;
        mask = par_on ? 24'h7f0000 : 24'hff0000;
        if (pos <= nt) begin
          case (pos)
            1: m_exp = mk(lbl[19:16], bcwf_pkg::CL_THI, time_hi);
            2: m_exp = mk(lbl[19:16], bcwf_pkg::CL_TLO, time_lo);
            3: m_exp = mk(lbl[19:16], bcwf_pkg::CL_TUS, time_us);
            default: m_exp = mk(lbl[19:16], bcwf_pkg::CL_TRSP, time_rsp);
          endcase
          check(fmt_word, m_exp, "time word");
        end else if (crc_on && pos == flen - 1) begin
          check(fmt_word, mk(lbl[11:8], lbl[15:12], crc), "crc word");
        end else if (exp_q.size() == 0) begin
          check(fmt_word, mk(lbl[3:0], lbl[7:4], bcwf_pkg::FILL_INFO), "fill");
        end else begin
          e = exp_q.pop_front();
          if (e[24])
            check(fmt_word & mask, mk(e[23:20], bcwf_pkg::CL_OVF, 16'h0) & mask, "marker");
          else
            check(fmt_word, mk(e[23:20], e[19:16], e[15:0]), "data");
        end
        if (par_on) check(^fmt_word, 1'b1, "odd parity");
        crc = crc_step(crc, fmt_word);
        pos++;
      end
    end
    if (rx_valid === 1'b1 && sent_q.size() > 0)
      check(rx_word, sent_q.pop_front(), "serial word");
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      $display("[ERR] %0t run timed out", $time);
      complete_run();
    end
  end

  initial begin
    {hsel, hwrite, cap_valid, ovf_evt, par_on, crc_on, tim_on, rsp_on} = 8'h00;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'b00;
    hsize = 3'b010;
    cap_word = 24'h000000;
    ovf_label = 4'h0;
    {time_hi, time_lo, time_us, time_rsp} = 64'hc001_8421_0f1e_7bde;
    {num_errors, comparisons, pos, cycles} = 128'h0;
    flen = 10'h080;
    lbl = 20'h37216;
    hresetn = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(bcwf_pkg::OFS_CTRL, 32'h00000000, "ctrl reset");
    rchk(bcwf_pkg::OFS_FLEN, 32'h00000080, "flen reset");
    rchk(bcwf_pkg::OFS_LBL, 32'h00007010, "lbl reset");
    rchk(8'h20, 32'h00000000, "unmapped read");
    ahb(1'b1, bcwf_pkg::OFS_FLEN, 32'h00000010, rd);
    rchk(bcwf_pkg::OFS_FLEN, 32'h00000080, "flen low clamp");
    ahb(1'b1, bcwf_pkg::OFS_FLEN, 32'h000003ff, rd);
    rchk(bcwf_pkg::OFS_FLEN, 32'h00000200, "flen high clamp");
    ahb(1'b1, bcwf_pkg::OFS_FLEN, 32'h00000410, rd);
    rchk(bcwf_pkg::OFS_FLEN, 32'h00000200, "flen upper bits clamp");
    ahb(1'b1, bcwf_pkg::OFS_FLEN, 32'h00000080, rd);
    ahb(1'b1, bcwf_pkg::OFS_LBL, {12'h000, lbl}, rd);
    rchk(bcwf_pkg::OFS_LBL, {12'h000, lbl}, "lbl write");
    $display("test registers done");
    {par_on, crc_on, tim_on, rsp_on} = 4'b1110;
    ahb(1'b1, bcwf_pkg::OFS_CTRL, 32'h0000000f, rd);
    cap(24'h5ac35a);
    cap(24'hd20f0f);
    cap(24'h188000);
    ovf(4'h6);
    cap(24'h24ffff);
    cap(24'h7eaaab);
    ahb(1'b1, bcwf_pkg::OFS_CTRL, 32'h00000001, rd);
    rchk(bcwf_pkg::OFS_CTRL, 32'h0000000f, "config frozen");
    stop_wait(32'h0000000e);
    rchk(bcwf_pkg::OFS_STAT, 32'h00000001, "frame count one");
    rchk(bcwf_pkg::OFS_OVFC, 32'h00000001, "overflow count one");
    $display("test parity crc time done");
    {par_on, crc_on, tim_on, rsp_on} = 4'b0011;
    ahb(1'b1, bcwf_pkg::OFS_CTRL, 32'h00000019, rd);
    cap(24'hb31357);
    ovf(4'hf);
    cap(24'h0c8421);
    stop_wait(32'h00000018);
    rchk(bcwf_pkg::OFS_STAT, 32'h00000002, "frame count two");
    rchk(bcwf_pkg::OFS_OVFC, 32'h00000002, "overflow count two");
    $display("test wide label response time done");
    repeat (200) @(posedge hclk);
    check(sent_q.size(), 0, "serial drain");
    complete_run();
  end
endmodule
